// *** verif/ltw_link_model.sv ***
/* Link-side model: makes wakeup, synch break and shift-load pulses.
   Assumes the flag block samples each pulse at one rising edge. */
`timescale 1ns/10ps
module ltw_link_model (
  input wire logic clk,
  input wire logic wake_blocked,
  output logic wakeup_sent,
  output logic synch_break_rx,
  output logic tx_shift_load
);
  // ------------------------------
  // Idle levels
  // ------------------------------
  initial begin
    wakeup_sent = 1'b0;
    synch_break_rx = 1'b0;
    tx_shift_load = 1'b0;
  end
  // Wakeup pulses, held off during expiry
  task wake(input int n);
    for (int i = 0; i < n; i++) begin
      while (wake_blocked === 1'b1) @(posedge clk);
      @(posedge clk);
      wakeup_sent <= 1'b1;
      @(posedge clk);
      wakeup_sent <= 1'b0;
    end
  endtask : wake
  // One synch break pulse
  task brk;
    @(posedge clk);
    synch_break_rx <= 1'b1;
    @(posedge clk);
    synch_break_rx <= 1'b0;
  endtask : brk
  // Buffer moved into shifter
  task load;
    @(posedge clk);
    tx_shift_load <= 1'b1;
    @(posedge clk);
    tx_shift_load <= 1'b0;
  endtask : load
endmodule : ltw_link_model

// *** verif/tb_lin_tx_ready_wakeup_timeout_flags.sv ***
/* Self-checking bench of the flag block.
   Assumes expiry shortened to 20 cycles and a 20 MHz clock. */
`timescale 1ns/10ps
`include "ltw_regs_map.svh"
module tb_lin_tx_ready_wakeup_timeout_flags;
  import ltw_pkg::*;
  // ------------------------------
  // Signals
  // ------------------------------
  localparam int TO = 20; // Short expiry
  logic clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, rdata, readdata_q;
  logic waitrequest_q, wakeup_sent, synch_break_rx, tx_shift_load, irq_q;
  ltw_flags_t flags_q;
  logic [7:0] tx_data_q;
  int errors = 0, samples_checked = 0;
  // Device and link partner
  ltw_flags #(.TIMEOUT_CYCLES(TO)) DUT (.clk(clk), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'h1), .readdata_q(readdata_q), .waitrequest_q(waitrequest_q),
    .wakeup_sent(wakeup_sent), .synch_break_rx(synch_break_rx),
    .tx_shift_load(tx_shift_load), .flags_q(flags_q), .tx_data_q(tx_data_q),
    .irq_q(irq_q));
  ltw_link_model lnk (.clk(clk), .wake_blocked(flags_q.wake_blocked),
    .wakeup_sent(wakeup_sent), .synch_break_rx(synch_break_rx),
    .tx_shift_load(tx_shift_load));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access, waits for waitrequest low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
    end while (waitrequest_q !== 1'b0);
    rdata = readdata_q;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // Wakeups, then the flag exactly TO cycles after the third
  task raise(input int n);
    lnk.wake(n);
    @(posedge clk);
    chk(flags_q.wake_blocked, 1'b1);
    repeat (TO - 1) @(posedge clk);
    chk(flags_q.wake_blocked, 1'b1);
    chk(flags_q.toa3, 1'b0);
    @(posedge clk);
    chk(flags_q.toa3, 1'b1);
    chk(flags_q.wake_blocked, 1'b0);
  endtask : raise
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_ready;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `LTW_OFF_CTRL, 32'h4 | m);
      chk(flags_q.tx_ready, 1'b1);
      bus(1'b1, `LTW_OFF_TXDATA, 32'hA5);
      @(posedge clk);
      chk(flags_q.tx_ready, 1'b0);
      chk(tx_data_q, 8'hA5);
      lnk.load();
      @(posedge clk);
      chk(flags_q.tx_ready, 1'b1);
    end
    $display("ready test done");
  endtask : t_ready
  task t_compat;
    bus(1'b1, `LTW_OFF_CTRL, 32'h4);
    lnk.wake(3);
    repeat (TO + 10) @(posedge clk);
    chk(flags_q.toa3, 1'b0);
    $display("compat test done");
  endtask : t_compat
  task t_vector;
    bus(1'b1, `LTW_OFF_CTRL, 32'h5);
    bus(1'b1, `LTW_OFF_INT_EN, 32'h2);
    raise(3);
    bus(1'b0, `LTW_OFF_FLAGS, 32'h0);
    chk(rdata[7], 1'b1);
    chk(irq_q, 1'b1);
    bus(1'b0, `LTW_OFF_INT_STAT, 32'h0);
    chk(rdata, 32'h3);
    bus(1'b0, `LTW_OFF_VECT, 32'h0);
    chk(rdata[7:0], `LTW_VEC_TOA3);
    @(posedge clk);
    chk(flags_q.toa3, 1'b0);
    bus(1'b1, `LTW_OFF_INT_CLR, 32'h2);
    @(posedge clk);
    chk(irq_q, 1'b0);
    bus(1'b0, 5'h1C, 32'h0);
    chk(rdata, 32'h0);
    $display("vector test done");
  endtask : t_vector
  task t_break;
    lnk.wake(2);
    lnk.brk();
    lnk.wake(1);
    repeat (TO + 10) @(posedge clk);
    chk(flags_q.toa3, 1'b0);
    raise(2);
    bus(1'b1, `LTW_OFF_FLAGS, 32'h0);
    @(posedge clk);
    chk(flags_q.toa3, 1'b1);
    bus(1'b1, `LTW_OFF_INT_EN, 32'h0);
    @(posedge clk);
    chk(irq_q, 1'b0);
    bus(1'b1, `LTW_OFF_FLAGS, 32'h80);
    @(posedge clk);
    chk(flags_q.toa3, 1'b0);
    $display("break test done");
  endtask : t_break
  task t_resets;
    for (int m = 0; m < 3; m++) begin
      raise(3);
      if (m == 2) begin
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
      end else begin
        bus(1'b1, `LTW_OFF_CTRL, m == 0 ? 32'h7 : 32'h1);
        // Soft reset clears the flag one edge after the control write
        repeat (2) @(posedge clk);
      end
      chk(flags_q.toa3, 1'b0);
      arst_n <= 1'b1;
      bus(1'b1, `LTW_OFF_CTRL, 32'h5);
    end
    $display("reset test done");
  endtask : t_resets
  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(flags_q, 3'b001);
    t_ready();
    t_compat();
    t_vector();
    t_break();
    t_resets();
    finish_test();
  end
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : tb_lin_tx_ready_wakeup_timeout_flags

// *** verilog/ltw_flags.sv ***
/*
  Transmit-ready and triple-wakeup-timeout flag logic with an Avalon-MM
  register slave and one level interrupt.
  Assumes one 20 MHz clock; wakeup_sent, synch_break_rx and tx_shift_load
  are one-cycle pulses synchronous to clk from the link logic.
*/
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "ltw_regs_map.svh"

// Notes on behaviour
// - Compat mode: ready 0 full, 1 free
// - LIN mode: ready 0 buffers full, 1 free
// - Timeout flag never set in compat mode
// - Set flag: three wakeups, 1.5 s, no break
// - Wait 1.5 s before next wakeup round
// - Vector read returning timeout code clears flag
// - Module reset, software reset, system reset clear
// - Write 1 clears flag, 0 leaves it
// - Reads 0 when no timeout occurred
// - Reads 1 once the timeout occurred
module ltw_flags #(
  parameter int unsigned TIMEOUT_CYCLES = `LTW_TOA3_MS * (`LTW_CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`LTW_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata_q,
  output logic waitrequest_q,
  input wire logic wakeup_sent,
  input wire logic synch_break_rx,
  input wire logic tx_shift_load,
  output ltw_pkg::ltw_flags_t flags_q,
  output logic [7:0] tx_data_q,
  output logic irq_q
);
  import ltw_pkg::*;

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam logic [`LTW_TMR_W-1:0] TMR_LAST = `LTW_TMR_W'(TIMEOUT_CYCLES - 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ltw_ctrl_t ctrl_q;                       // Software control bits
  logic [1:0] wake_cnt_q;                  // Wakeups sent this round
  logic timer_run_q;                       // Expiration timer running
  logic [`LTW_TMR_W-1:0] timer_q;          // Expiration timer count
  logic [`LTW_EVT_W-1:0] int_stat_q;       // Sticky event bits
  logic [`LTW_EVT_W-1:0] int_en_q;         // Event enables

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire req = read | write;                 // Request pending
  wire commit = req & ~waitrequest_q;      // Edge that completes access
  wire wr_go = commit & write;
  wire rd_go = commit & read;
  wire lane0 = byteenable[0];
  wire hit_ctrl = address == `LTW_OFF_CTRL;
  wire hit_flags = address == `LTW_OFF_FLAGS;
  wire hit_vect = address == `LTW_OFF_VECT;
  wire hit_txd = address == `LTW_OFF_TXDATA;
  wire hit_stat = address == `LTW_OFF_INT_STAT;
  wire hit_clr = address == `LTW_OFF_INT_CLR;
  wire hit_en = address == `LTW_OFF_INT_EN;

  // ---------------------------------------------------------------
  // Soft resets and events
  // ---------------------------------------------------------------
  wire soft_rst = ctrl_q.module_reset | ~ctrl_q.sw_release;
  wire lin_act = ctrl_q.lin_mode & ~soft_rst;
  wire third_wake = lin_act & wakeup_sent & ~timer_run_q
                    & (wake_cnt_q == `LTW_WAKE_ROUND - 2'h1);
  wire expire = timer_run_q & (timer_q == TMR_LAST);
  wire toa3_set = expire & lin_act & ~synch_break_rx;
  wire toa3_w1c = wr_go & hit_flags & lane0 & writedata[`LTW_FLAG_TOA3_BIT];
  // Clear judged on the code actually returned, not on the current flag
  wire vect_clr = rd_go & hit_vect & (readdata_q[7:0] == `LTW_VEC_TOA3);
  wire txd_wr = wr_go & hit_txd & lane0;
  wire tx_buffer_ready_flag_set = tx_shift_load & ~flags_q.tx_ready & ~soft_rst;
  wire [`LTW_EVT_W-1:0] evt = {toa3_set, tx_buffer_ready_flag_set};
  wire [`LTW_EVT_W-1:0] int_clr = (wr_go & hit_clr & lane0) ?
                                  writedata[`LTW_EVT_W-1:0] : '0;
  wire [`LTW_EVT_W-1:0] int_stat_d = (int_stat_q & ~int_clr) | evt;
  // Enable value after this edge, so the interrupt follows an enable write
  wire [`LTW_EVT_W-1:0] int_en_d = (wr_go & hit_en & lane0) ?
                                   writedata[`LTW_EVT_W-1:0] : int_en_q;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [7:0] vect_code = flags_q.toa3 ? `LTW_VEC_TOA3 :
                         (flags_q.tx_ready & int_en_q[`LTW_EVT_TX_BUFFER_READY_FLAG_BIT]) ?
                         `LTW_VEC_TX_BUFFER_READY_FLAG : `LTW_VEC_NONE;
  wire [31:0] flags_word = {23'h0, flags_q.tx_ready, flags_q.toa3, 7'h0};
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_q} :
                       hit_flags ? flags_word :
                       hit_vect ? {24'h0, vect_code} :
                       hit_txd ? {24'h0, tx_data_q} :
                       hit_stat ? {30'h0, int_stat_q} :
                       hit_en ? {30'h0, int_en_q} : 32'h0;

  // ---------------------------------------------------------------
  // Bus handshake: one wait cycle per access
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0;
    end else begin
      waitrequest_q <= ~(req & waitrequest_q);
      // Data taken at the request edge stands at the answer edge
      if (read & waitrequest_q) begin
        readdata_q <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and interrupt registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `LTW_CTRL_RST;
      int_en_q <= '0;
      int_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_go & hit_ctrl & lane0) begin
        ctrl_q <= writedata[2:0];
      end
      if (wr_go & hit_en & lane0) begin
        int_en_q <= writedata[`LTW_EVT_W-1:0];
      end
      int_stat_q <= int_stat_d;          // Event wins over clear
      irq_q <= |(int_stat_d & int_en_d);
    end
  end

  // ---------------------------------------------------------------
  // Transmit data register
  // ---------------------------------------------------------------
  // The ready flag lives with the other flag fields in one process
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data_q <= 8'h0;
    end else begin
      if (txd_wr & ~soft_rst) begin
        tx_data_q <= writedata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Wakeup counter and expiration timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt_q <= 2'h0;
      timer_run_q <= 1'b0;
      timer_q <= '0;
    end else begin
      if (!lin_act | synch_break_rx | expire) begin
        wake_cnt_q <= 2'h0;
        timer_run_q <= 1'b0;
        timer_q <= '0;
      end else if (third_wake) begin
        wake_cnt_q <= `LTW_WAKE_ROUND;
        timer_run_q <= 1'b1;
      // Wakeups arriving while the timer runs are ignored
      end else if (timer_run_q) begin
        timer_q <= timer_q + `LTW_TMR_W'(1);
      end else if (wakeup_sent) begin
        wake_cnt_q <= wake_cnt_q + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag fields: ready, timeout and wakeup hold-off
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q.tx_ready <= 1'b1;
      flags_q.toa3 <= 1'b0;
      flags_q.wake_blocked <= 1'b0;
    end else begin
      // Soft reset first, then a new character, then a shifter load
      if (soft_rst) begin
        flags_q.tx_ready <= 1'b1;
      end else if (txd_wr) begin
        flags_q.tx_ready <= 1'b0;
      end else if (tx_shift_load) begin
        flags_q.tx_ready <= 1'b1;
      end
      // Soft reset first, then the set, then either clear
      if (soft_rst) begin
        flags_q.toa3 <= 1'b0;
      end else if (toa3_set) begin
        flags_q.toa3 <= 1'b1;
      end else if (toa3_w1c | vect_clr) begin
        flags_q.toa3 <= 1'b0;
      end
      flags_q.wake_blocked <= (third_wake | timer_run_q) & ~expire
                              & lin_act & ~synch_break_rx;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  compat_no_set_a: assert property (
    !ctrl_q.lin_mode |=> !$rose(flags_q.toa3))
    else $error("timeout flag set in compatibility mode");
  timeout_sets_a: assert property (
    toa3_set |=> flags_q.toa3)
    else $error("timeout did not set flag");
  set_needs_expiry_a: assert property (
    $rose(flags_q.toa3) |-> $past(timer_q) == TMR_LAST && $past(timer_run_q))
    else $error("flag set without full expiration");
  hold_off_a: assert property (
    third_wake |=> flags_q.wake_blocked [*8])
    else $error("wakeup round not held off");
  vect_clear_a: assert property (
    vect_clr && !toa3_set |=> !flags_q.toa3)
    else $error("vector read did not clear flag");
  soft_reset_a: assert property (
    soft_rst |=> !flags_q.toa3 && flags_q.tx_ready)
    else $error("soft reset did not clear flags");
  w1c_a: assert property (
    wr_go && hit_flags && !writedata[`LTW_FLAG_TOA3_BIT] && flags_q.toa3
    && !soft_rst |=> flags_q.toa3)
    else $error("writing 0 changed timeout flag");
  read_flag_a: assert property (
    read && waitrequest_q && hit_flags |=> readdata_q[`LTW_FLAG_TOA3_BIT] == $past(flags_q.toa3))
    else $error("flag readback wrong");
  tx_buffer_ready_flag_clear_a: assert property (
    txd_wr && !soft_rst |=> !flags_q.tx_ready)
    else $error("data write left ready set");
  tx_buffer_ready_flag_set_a: assert property (
    tx_shift_load && !txd_wr && !soft_rst |=> flags_q.tx_ready)
    else $error("shift load did not set ready");
  break_restart_a: assert property (
    synch_break_rx |=> wake_cnt_q == 2'h0 && !timer_run_q && timer_q == '0)
    else $error("break did not restart wakeup round");

  // ---------------------------------------------------------------
  // Checks on the bus handshake, interrupt and round timing
  // ---------------------------------------------------------------

  // A request is answered after exactly one wait cycle
  bus_answer_a: assert property (
    req && waitrequest_q |=> !waitrequest_q)
    else $error("request not answered after one wait cycle");

  // The answer stands for one cycle only
  bus_release_a: assert property (
    !waitrequest_q |=> waitrequest_q)
    else $error("waitrequest stayed low");

  // Interrupt level follows enabled status with no lag
  irq_level_a: assert property (
    irq_q == |(int_stat_q & int_en_q))
    else $error("interrupt level disagrees with status");

  // Expiry ends the hold-off and stops the timer
  expiry_release_a: assert property (
    expire |=> !flags_q.wake_blocked && !timer_run_q)
    else $error("hold-off not released at expiry");

  // A break in the expiry cycle suppresses the flag
  break_no_set_a: assert property (
    synch_break_rx |=> !$rose(flags_q.toa3))
    else $error("timeout flag set despite synch break");

  // Outside LIN mode no wakeup round is counted
  compat_idle_a: assert property (
    !lin_act |=> wake_cnt_q == 2'h0 && !timer_run_q)
    else $error("wakeup round counted outside LIN mode");

  // The running timer advances by one each cycle
  timer_step_a: assert property (
    timer_run_q && !expire && lin_act && !synch_break_rx
    |=> timer_q == $past(timer_q) + `LTW_TMR_W'(1))
    else $error("expiration timer skipped a count");

  // The third wakeup starts the timer from zero
  round_start_a: assert property (
    third_wake && !synch_break_rx |=> timer_run_q && timer_q == '0)
    else $error("third wakeup did not start the timer");

  // A written character lands in the data register
  tx_data_a: assert property (
    txd_wr && !soft_rst |=> tx_data_q == $past(writedata[7:0]))
    else $error("character not stored");

endmodule : ltw_flags

// *** verilog/ltw_pkg.sv ***
/*
  Types shared by the flag block and its bench.
  Assumes the map header supplies all numeric constants.
*/
package ltw_pkg;

  // Control bits written by software
  typedef struct packed {
    logic sw_release;  // Released from software reset when 1
    logic module_reset; // Holds flags in reset when 1
    logic lin_mode;    // LIN mode when 1, compatibility when 0
  } ltw_ctrl_t;

  // Flag outputs toward the rest of the controller
  typedef struct packed {
    logic wake_blocked; // No new wakeup round allowed
    logic toa3;         // Triple-wakeup timeout flag
    logic tx_ready;     // Transmit buffer ready flag
  } ltw_flags_t;

endpackage : ltw_pkg

// *** verilog/ltw_regs_map.svh ***
/*
  Register offsets, field positions, reset values and timing figures of the
  LIN wakeup-timeout and transmit-ready flag block.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
`ifndef LTW_REGS_MAP_SVH
`define LTW_REGS_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define LTW_ADDR_W 5
`define LTW_OFF_CTRL 5'h00
`define LTW_OFF_FLAGS 5'h04
`define LTW_OFF_VECT 5'h08
`define LTW_OFF_TXDATA 5'h0C
`define LTW_OFF_INT_STAT 5'h10
`define LTW_OFF_INT_CLR 5'h14
`define LTW_OFF_INT_EN 5'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LTW_CTRL_LIN_BIT 0
`define LTW_CTRL_MRST_BIT 1
`define LTW_CTRL_SWREL_BIT 2
`define LTW_FLAG_TOA3_BIT 7
`define LTW_FLAG_TX_BUFFER_READY_FLAG_BIT 8
`define LTW_EVT_TX_BUFFER_READY_FLAG_BIT 0
`define LTW_EVT_TOA3_BIT 1
`define LTW_EVT_W 2

// ---------------------------------------------------------------
// Reset values and vector codes
// ---------------------------------------------------------------
`define LTW_CTRL_RST 3'h0
`define LTW_VEC_NONE 8'h00
`define LTW_VEC_TOA3 8'h0B
`define LTW_VEC_TX_BUFFER_READY_FLAG 8'h0C
`define LTW_WAKE_ROUND 2'h3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LTW_CLK_HZ 20000000
`define LTW_TOA3_MS 1500
`define LTW_TMR_W 25

`endif
